// *** core/cpn_pkg.sv ***
// constants and types of the charger protection and thermistor configuration bank
package cpn_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int         AW          = 8;
   localparam int         DW          = 8;
   localparam logic [7:0] OFS_LIMITS  = 8'h19;
   localparam logic [7:0] OFS_THM_OTG = 8'h1a;
   localparam logic [7:0] OFS_THM_TH  = 8'h1b;
   localparam logic [7:0] OFS_CTRL    = 8'h20;
   localparam logic [7:0] RST_LIMITS  = 8'hc4;
   localparam logic [7:0] RST_THM_OTG = 8'h3d;
   localparam logic [7:0] RST_THM_TH  = 8'h25;
   localparam logic [1:0] RST_WD_PER  = 2'h1;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // -----------------------------------------------------------------
   // control register bit positions
   // -----------------------------------------------------------------
   localparam int CTRL_REG_RST  = 7;
   localparam int CTRL_WD_FLAG  = 3;
   localparam int CTRL_WD_KICK  = 2;
   localparam int CTRL_WD_PER_H = 1;
   localparam int CTRL_WD_PER_L = 0;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam longint unsigned CLK_HZ      = 100_000_000;
   localparam longint unsigned WD_BASE_S   = 50;
   localparam longint unsigned WD_BASE_CYC = WD_BASE_S * CLK_HZ;
   localparam int              WD_CW       = 36;

   // -----------------------------------------------------------------
   // field layouts
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] discharge_peak_limit;
      logic       battery_lockout_threshold;
      logic       boost_start_min_voltage;
      logic       rsvd;
      logic       ext_current_pin_enable;
      logic [1:0] fast_charge_rate;
   } cpn_limits_t;

   typedef struct packed {
      logic       thermistor_bypass;
      logic [1:0] boost_hot_limit;
      logic       boost_cold_limit;
      logic [1:0] warm_zone_current;
      logic [1:0] cool_zone_current;
   } cpn_thm_otg_t;

   typedef enum logic [2:0] {
      CPN_THM_OK,
      CPN_THM_WARM,
      CPN_THM_COOL,
      CPN_THM_COLD,
      CPN_THM_HOT
   } cpn_thm_t;

   typedef struct packed {
      cpn_limits_t  limits;
      cpn_thm_otg_t thm_otg;
      logic [7:0]   thm_th;
   } cpn_cfg_t;

endpackage : cpn_pkg

// *** core/cpn_regs.sv ***
// configuration bank with watchdog, thermistor bypass and fold-back current
`timescale 1ns/1ps
module cpn_regs
   import cpn_pkg::*;
#(
   parameter int          CHARGE_CURRENT_SETTING_W         = 8,
   parameter int          RATIO_W        = 8,
   parameter bit          VARIANT_B      = 1'b0,
   parameter logic [35:0] WD_BASE_CYCLES = 36'(WD_BASE_CYC)
) (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      srst_i,
   // register port
   input  wire logic [AW-1:0]             addr_i,
   input  wire logic [DW-1:0]             wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [DW-1:0]             rdata_o,
   // charger side
   input  wire logic [CHARGE_CURRENT_SETTING_W-1:0]         charge_current_setting_i,
   input  wire logic [RATIO_W-1:0]        foldback_ratio_i,
   input  wire cpn_thm_t                  thermistor_state_i,
   output cpn_cfg_t                       cfg_o,
   output cpn_thm_t                       thermistor_state_o,
   output logic                           thermistor_good_o,
   output logic      [CHARGE_CURRENT_SETTING_W+RATIO_W-1:0] foldback_current_o,
   output logic      [CHARGE_CURRENT_SETTING_W-1:0]         zone_current_o,
   output logic                           wd_expired_o
);

   localparam int PW = CHARGE_CURRENT_SETTING_W + RATIO_W;
   localparam logic EXT_DEF = ~VARIANT_B;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      cpn_limits_t       limits;
      cpn_thm_otg_t      thm_otg;
      logic [7:0]        thm_th;
      logic [1:0]        wd_per;
      logic              wd_flag;
      logic [WD_CW-1:0]  wd_cnt;
      logic [DW-1:0]     rdata;
      cpn_thm_t          thm;
      logic              thm_good;
      logic [PW-1:0]     fold;
      logic [CHARGE_CURRENT_SETTING_W-1:0] zone;
      logic              wd_exp;
   } cpn_state_t;

   cpn_state_t st_r;
   cpn_state_t st_nxt;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [2:0] rate_div(input logic [1:0] code);
      case (code)
         2'h0:    rate_div = 3'h1;
         2'h1:    rate_div = 3'h2;
         2'h2:    rate_div = 3'h4;
         default: rate_div = 3'h6;
      endcase
   endfunction : rate_div

   function automatic logic [CHARGE_CURRENT_SETTING_W-1:0] zone_scale(input logic [1:0]        code,
                                                    input logic [CHARGE_CURRENT_SETTING_W-1:0] charge_current_setting);
      logic [CHARGE_CURRENT_SETTING_W+6:0] p;
      p = '0;
      case (code)
         2'h0:    zone_scale = '0;
         2'h1: begin
            p          = (CHARGE_CURRENT_SETTING_W+7)'(charge_current_setting) * (CHARGE_CURRENT_SETTING_W+7)'(20);
            zone_scale = CHARGE_CURRENT_SETTING_W'(p / (CHARGE_CURRENT_SETTING_W+7)'(100));
         end
         2'h2: begin
            p          = (CHARGE_CURRENT_SETTING_W+7)'(charge_current_setting) * (CHARGE_CURRENT_SETTING_W+7)'(40);
            zone_scale = CHARGE_CURRENT_SETTING_W'(p / (CHARGE_CURRENT_SETTING_W+7)'(100));
         end
         default: zone_scale = charge_current_setting;
      endcase
   endfunction : zone_scale

   function automatic logic [WD_CW-1:0] wd_limit(input logic [1:0] per);
      case (per)
         2'h1:    wd_limit = WD_BASE_CYCLES;
         2'h2:    wd_limit = WD_CW'(WD_BASE_CYCLES << 1);
         default: wd_limit = WD_CW'(WD_BASE_CYCLES << 2);
      endcase
   endfunction : wd_limit

   logic [PW-1:0] fold_prod;
   assign fold_prod = PW'(charge_current_setting_i) * PW'(foldback_ratio_i);

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic     wr_lim;
      logic     wr_otg;
      logic     wr_th;
      logic     wr_ctl;
      logic     reg_rst;
      logic     kick;
      logic     expire;
      cpn_thm_t eff;
      wr_lim  = wr_i && (addr_i == OFS_LIMITS);
      wr_otg  = wr_i && (addr_i == OFS_THM_OTG);
      wr_th   = wr_i && (addr_i == OFS_THM_TH);
      wr_ctl  = wr_i && (addr_i == OFS_CTRL);
      reg_rst = wr_ctl && wdata_i[CTRL_REG_RST];
      kick    = wr_ctl && wdata_i[CTRL_WD_KICK];
      expire  = (st_r.wd_per != 2'h0) && (st_r.wd_cnt >= wd_limit(st_r.wd_per) - 36'h1);
      eff     = st_r.thm_otg.thermistor_bypass ? CPN_THM_OK : thermistor_state_i;
      st_nxt  = st_r;

      // register writes
      if (wr_lim) begin
         st_nxt.limits.discharge_peak_limit      = wdata_i[7:6];
         st_nxt.limits.battery_lockout_threshold = wdata_i[5];
         st_nxt.limits.boost_start_min_voltage   = wdata_i[4];
         st_nxt.limits.rsvd                      = 1'b0;
         if (!VARIANT_B) begin
            st_nxt.limits.ext_current_pin_enable = wdata_i[2];
         end
         st_nxt.limits.fast_charge_rate          = wdata_i[1:0];
      end
      if (wr_otg) begin
         st_nxt.thm_otg = cpn_thm_otg_t'(wdata_i);
      end
      if (wr_th) begin
         st_nxt.thm_th = wdata_i;
      end
      if (wr_ctl) begin
         st_nxt.wd_per = wdata_i[CTRL_WD_PER_H:CTRL_WD_PER_L];
         if (wdata_i[CTRL_WD_FLAG]) begin
            st_nxt.wd_flag = 1'b0;
         end
      end

      // watchdog
      st_nxt.wd_exp = 1'b0;
      if (reg_rst || kick || st_r.wd_per == 2'h0) begin
         st_nxt.wd_cnt = '0;
      end else if (expire) begin
         st_nxt.wd_cnt                        = '0;
         st_nxt.wd_exp                        = 1'b1;
         st_nxt.wd_flag                       = 1'b1;
         st_nxt.limits.ext_current_pin_enable = EXT_DEF;
         st_nxt.thm_otg.thermistor_bypass     = 1'b0;
      end else begin
         st_nxt.wd_cnt = st_r.wd_cnt + 36'h1;
      end

      // register reset command, self clearing
      if (reg_rst) begin
         st_nxt.limits                        = cpn_limits_t'(RST_LIMITS);
         st_nxt.limits.ext_current_pin_enable = EXT_DEF;
         st_nxt.thm_otg                       = cpn_thm_otg_t'(RST_THM_OTG);
         st_nxt.thm_th                        = RST_THM_TH;
         st_nxt.wd_per                        = RST_WD_PER;
      end

      // read data, one cycle after the strobe
      st_nxt.rdata = '0;
      if (rd_i) begin
         if (addr_i == OFS_LIMITS) begin
            st_nxt.rdata = st_r.limits & 8'hf7;
         end else if (addr_i == OFS_THM_OTG) begin
            st_nxt.rdata = st_r.thm_otg;
         end else if (addr_i == OFS_THM_TH) begin
            st_nxt.rdata = st_r.thm_th;
         end else if (addr_i == OFS_CTRL) begin
            st_nxt.rdata = {4'h0, st_r.wd_flag, 1'b0, st_r.wd_per};
         end else begin
            st_nxt.rdata = RD_UNMAPPED;
         end
      end

      // thermistor view
      st_nxt.thm      = eff;
      st_nxt.thm_good = (eff == CPN_THM_OK);
      if (eff == CPN_THM_WARM) begin
         st_nxt.zone = zone_scale(st_r.thm_otg.warm_zone_current,
                                  charge_current_setting_i);
      end else if (eff == CPN_THM_COOL) begin
         st_nxt.zone = zone_scale(st_r.thm_otg.cool_zone_current,
                                  charge_current_setting_i);
      end else if (eff == CPN_THM_OK) begin
         st_nxt.zone = charge_current_setting_i;
      end else begin
         st_nxt.zone = '0;
      end

      // fold-back current
      st_nxt.fold = fold_prod / PW'(rate_div(st_r.limits.fast_charge_rate));

      if (srst_i) begin
         st_nxt                               = '0;
         st_nxt.limits                        = cpn_limits_t'(RST_LIMITS);
         st_nxt.limits.ext_current_pin_enable = EXT_DEF;
         st_nxt.thm_otg                       = cpn_thm_otg_t'(RST_THM_OTG);
         st_nxt.thm_th                        = RST_THM_TH;
         st_nxt.wd_per                        = RST_WD_PER;
         st_nxt.thm                           = CPN_THM_OK;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign rdata_o            = st_r.rdata;
   assign cfg_o              = '{limits:  st_r.limits,
                                 thm_otg: st_r.thm_otg,
                                 thm_th:  st_r.thm_th};
   assign thermistor_state_o = st_r.thm;
   assign thermistor_good_o  = st_r.thm_good;
   assign foldback_current_o = st_r.fold;
   assign zone_current_o     = st_r.zone;
   assign wd_expired_o       = st_r.wd_exp;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   AST_RESET_VALUES: assert property (
      $past(srst_i) |-> (st_r.limits == {RST_LIMITS[7:3], EXT_DEF, RST_LIMITS[1:0]})
                        && (st_r.thm_otg == RST_THM_OTG) && (st_r.thm_th == RST_THM_TH))
      else $error("reset values wrong");

   AST_PEAK_WRITE: assert property (
      (wr_i && addr_i == OFS_LIMITS && !(wr_i && addr_i == OFS_CTRL))
      |=> (st_r.limits.discharge_peak_limit == $past(wdata_i[7:6])))
      else $error("peak limit not stored");

   AST_RATE_WRITE: assert property (
      (wr_i && addr_i == OFS_LIMITS) |=> (cfg_o.limits.fast_charge_rate == $past(wdata_i[1:0])))
      else $error("charge rate not stored");

   AST_RSVD_ZERO: assert property (
      (rd_i && addr_i == OFS_LIMITS) |=> (rdata_o[3] == 1'b0))
      else $error("reserved bit reads one");

   AST_READBACK: assert property (
      (rd_i && addr_i == OFS_THM_OTG) |=> (rdata_o == $past(st_r.thm_otg)))
      else $error("thermistor register readback wrong");

   AST_REG_RESET: assert property (
      (wr_i && addr_i == OFS_CTRL && wdata_i[CTRL_REG_RST])
      |=> (st_r.thm_otg == RST_THM_OTG) && (st_r.thm_th == RST_THM_TH)
          && (st_r.wd_cnt == '0) && (st_r.limits.fast_charge_rate == 2'h0))
      else $error("register reset incomplete");

   AST_WD_EXPIRY: assert property (
      wd_expired_o |-> !st_r.thm_otg.thermistor_bypass
                       && (st_r.limits.ext_current_pin_enable == EXT_DEF) && st_r.wd_flag)
      else $error("watchdog expiry did not restore fields");

   AST_WD_OFF: assert property (
      (st_r.wd_per == 2'h0) |=> !wd_expired_o)
      else $error("disabled watchdog expired");

   AST_BYPASS: assert property (
      $past(st_r.thm_otg.thermistor_bypass) |-> thermistor_good_o
                                                && (thermistor_state_o == CPN_THM_OK))
      else $error("bypass did not report good");

   AST_FOLDBACK: assert property (
      !srst_i |=> (foldback_current_o
                   == $past(fold_prod) / PW'(rate_div($past(cfg_o.limits.fast_charge_rate)))))
      else $error("fold-back current wrong");

   AST_WARM_SUSPEND: assert property (
      (!st_r.thm_otg.thermistor_bypass && thermistor_state_i == CPN_THM_WARM
       && st_r.thm_otg.warm_zone_current == 2'h0) |=> (zone_current_o == '0))
      else $error("warm suspend not applied");

   AST_COOL_KEEP: assert property (
      (!st_r.thm_otg.thermistor_bypass && thermistor_state_i == CPN_THM_COOL
       && st_r.thm_otg.cool_zone_current == 2'h3)
      |=> (zone_current_o == $past(charge_current_setting_i)))
      else $error("cool unchanged current wrong");

   AST_LIMIT_FIELDS: assert property (
      (wr_i && addr_i == OFS_LIMITS)
      |=> (st_r.limits.battery_lockout_threshold == $past(wdata_i[5]))
          && (st_r.limits.boost_start_min_voltage == $past(wdata_i[4])))
      else $error("lockout or boost start level not stored");

   AST_OTG_FIELDS: assert property (
      (wr_i && addr_i == OFS_THM_OTG)
      |=> (st_r.thm_otg.boost_hot_limit == $past(wdata_i[6:5]))
          && (st_r.thm_otg.boost_cold_limit == $past(wdata_i[4])))
      else $error("boost temperature limits not stored");

   AST_RSVD_HELD: assert property (
      st_r.limits.rsvd == 1'b0)
      else $error("reserved bit stored a one");

   AST_EXT_VARIANT: assert property (
      VARIANT_B |-> !st_r.limits.ext_current_pin_enable)
      else $error("reserved pin enable bit set on second variant");

   AST_THM_FOLLOW: assert property (
      (!srst_i && !st_r.thm_otg.thermistor_bypass)
      |=> (thermistor_state_o == $past(thermistor_state_i))
          && (thermistor_good_o == (thermistor_state_o == CPN_THM_OK)))
      else $error("thermistor state not passed through");

   AST_CTRL_SELF_CLEAR: assert property (
      (rd_i && addr_i == OFS_CTRL)
      |=> (rdata_o[CTRL_REG_RST] == 1'b0) && (rdata_o[CTRL_WD_KICK] == 1'b0))
      else $error("command bits read back set");

   COV_REG_RESET:  cover property (wr_i && addr_i == OFS_CTRL && wdata_i[CTRL_REG_RST]);
   COV_WD_EXPIRE:  cover property (wd_expired_o);
   COV_BYPASS:     cover property (st_r.thm_otg.thermistor_bypass && thermistor_good_o);
   COV_UNMAPPED:   cover property (rd_i && !(addr_i inside {OFS_LIMITS, OFS_THM_OTG,
                                                           OFS_THM_TH, OFS_CTRL}));
   COV_WARM_ZONE:  cover property (thermistor_state_i == CPN_THM_WARM
                                   && !st_r.thm_otg.thermistor_bypass);

endmodule : cpn_regs

// *** verif/tb_top.sv ***
// self-checking bench for the charger protection and thermistor configuration bank
`timescale 1ns/1ps
module tb_top;
   import cpn_pkg::*;

   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } cpn_tb_row_t;

   localparam int     WD_LIM = 20;
   logic              clk_i  = 1'b0;
   logic              srst_i = 1'b1;
   logic [AW-1:0]     addr_i = 8'h00;
   logic [DW-1:0]     wdata_i = 8'h00;
   logic              wr_i   = 1'b0;
   logic              rd_i   = 1'b0;
   logic [DW-1:0]     rdata_o;
   logic [7:0]        charge_current_setting   = 8'hc8;
   logic [7:0]        ratio  = 8'h03;
   cpn_thm_t          thm_in = CPN_THM_OK;
   cpn_cfg_t          cfg_o;
   cpn_thm_t          thm_out;
   logic              good;
   logic [15:0]       fold;
   logic [7:0]        zone;
   logic              wd_exp;
   int                fails = 0;
   int                tests_run = 0;
   int                cyc = 0;
   cpn_cfg_t          cfg_b;
   int                n;
   cpn_tb_row_t       rows [9] = '{
      '{8'h19, 8'hff, 8'hf7}, '{8'h19, 8'h80, 8'h80}, '{8'h19, 8'h2b, 8'h23},
      '{8'h19, 8'h11, 8'h11}, '{8'h1a, 8'h80, 8'h80}, '{8'h1a, 8'h55, 8'h55},
      '{8'h1a, 8'haa, 8'haa}, '{8'h1b, 8'h5a, 8'h5a}, '{8'h21, 8'hff, 8'h00}};
   logic [15:0]       fold_exp [4] = '{16'h0258, 16'h012c, 16'h0096, 16'h0064};
   logic [7:0]        zone_exp [4] = '{8'h00, 8'h28, 8'h50, 8'hc8};

   cpn_regs #(.CHARGE_CURRENT_SETTING_W(8), .RATIO_W(8), .VARIANT_B(1'b0), .WD_BASE_CYCLES(36'd20)) u_dut (
      .clk_i                    (clk_i),
      .srst_i                   (srst_i),
      .addr_i                   (addr_i),
      .wdata_i                  (wdata_i),
      .wr_i                     (wr_i),
      .rd_i                     (rd_i),
      .rdata_o                  (rdata_o),
      .charge_current_setting_i (charge_current_setting),
      .foldback_ratio_i         (ratio),
      .thermistor_state_i       (thm_in),
      .cfg_o                    (cfg_o),
      .thermistor_state_o       (thm_out),
      .thermistor_good_o        (good),
      .foldback_current_o       (fold),
      .zone_current_o           (zone),
      .wd_expired_o             (wd_exp)
   );

   cpn_regs #(.CHARGE_CURRENT_SETTING_W(8), .RATIO_W(8), .VARIANT_B(1'b1), .WD_BASE_CYCLES(36'd20)) u_dut_b (
      .clk_i                    (clk_i),
      .srst_i                   (srst_i),
      .addr_i                   (addr_i),
      .wdata_i                  (wdata_i),
      .wr_i                     (wr_i),
      .rd_i                     (rd_i),
      .rdata_o                  (),
      .charge_current_setting_i (charge_current_setting),
      .foldback_ratio_i         (ratio),
      .thermistor_state_i       (thm_in),
      .cfg_o                    (cfg_b),
      .thermistor_state_o       (),
      .thermistor_good_o        (),
      .foldback_current_o       (),
      .zone_current_o           (),
      .wd_expired_o             ()
   );

   // -----------------------------------------------------------------
   // clock and timeout
   // -----------------------------------------------------------------
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         $display("mismatch at %0t: timeout", $time);
         close_out();
      end
   end

   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
      @(posedge clk_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
      @(posedge clk_i);
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      check({8'h00, v}, {8'h00, e});
   endtask : rd_chk

   task automatic pulse_wait(input int lim, output int k);
      k = 0;
      do begin
         @(posedge clk_i);
         #1 k = k + 1;
      end while (wd_exp !== 1'b1 && k < lim);
   endtask : pulse_wait

   task automatic close_out();
      if (fails == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(OFS_CTRL, 8'h01);
      wr(OFS_CTRL, 8'h04);
      rd_chk(OFS_LIMITS, 8'hc4);
      rd_chk(OFS_THM_OTG, 8'h3d);
      rd_chk(OFS_THM_TH, 8'h25);
      #1 check({8'h00, rdata_o}, 16'h0000);
      check({8'h00, cfg_b.limits}, 16'h00c0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
         if (rows[i].a == OFS_LIMITS) begin
            check({8'h00, cfg_o.limits}, {8'h00, rows[i].e});
            check({8'h00, cfg_b.limits}, {8'h00, rows[i].e & 8'hfb});
         end
      end
      for (int r = 0; r < 4; r++) begin
         wr(OFS_LIMITS, 8'hc4 | 8'(r));
         repeat (3) @(posedge clk_i);
         #1 check(fold, fold_exp[r]);
         @(posedge clk_i);
      end
      charge_current_setting  <= 8'h64;
      ratio <= 8'h07;
      repeat (3) @(posedge clk_i);
      #1 check(fold, 16'h0074);
      @(posedge clk_i);
      charge_current_setting  <= 8'hc8;
      ratio <= 8'h03;
      for (int c = 0; c < 4; c++) begin
         wr(OFS_THM_OTG, 8'h30 | 8'(c << 2) | 8'(c));
         thm_in <= CPN_THM_WARM;
         repeat (3) @(posedge clk_i);
         #1 check({8'h00, zone}, {8'h00, zone_exp[c]});
         @(posedge clk_i);
         thm_in <= CPN_THM_COOL;
         repeat (3) @(posedge clk_i);
         #1 check({8'h00, zone}, {8'h00, zone_exp[c]});
         @(posedge clk_i);
      end
      thm_in <= CPN_THM_HOT;
      wr(OFS_THM_OTG, 8'h30);
      repeat (3) @(posedge clk_i);
      #1 check({13'h0, thm_out}, {13'h0, CPN_THM_HOT});
      check({15'h0, good}, 16'h0000);
      @(posedge clk_i);
      wr(OFS_THM_OTG, 8'hb0);
      repeat (3) @(posedge clk_i);
      #1 check({13'h0, thm_out}, {13'h0, CPN_THM_OK});
      check({15'h0, good}, 16'h0001);
      @(posedge clk_i);
      // register reset command restores every default except the watchdog flag
      wr(OFS_LIMITS, 8'h00);
      wr(OFS_THM_TH, 8'hff);
      wr(OFS_CTRL, 8'h83);
      rd_chk(OFS_LIMITS, 8'hc4);
      rd_chk(OFS_THM_OTG, 8'h3d);
      rd_chk(OFS_THM_TH, 8'h25);
      rd_chk(OFS_CTRL, 8'h01);
      // watchdog expiry restores its fields
      wr(OFS_CTRL, 8'h04);
      wr(OFS_LIMITS, 8'hc0);
      wr(OFS_THM_OTG, 8'hbd);
      rd_chk(OFS_LIMITS, 8'hc0);
      wr(OFS_CTRL, 8'h05);
      pulse_wait(4 * WD_LIM, n);
      check({15'h0, wd_exp}, 16'h0001);
      @(posedge clk_i);
      wr(OFS_CTRL, 8'h04);
      rd_chk(OFS_LIMITS, 8'hc4);
      rd_chk(OFS_THM_OTG, 8'h3d);
      rd_chk(OFS_CTRL, 8'h08);
      wr(OFS_CTRL, 8'h0c);
      rd_chk(OFS_CTRL, 8'h00);
      for (int p = 1; p < 4; p++) begin
         wr(OFS_CTRL, 8'h04 | 8'(p));
         pulse_wait(20 * WD_LIM, n);
         pulse_wait(20 * WD_LIM, n);
         check(16'(n), 16'(WD_LIM << (p - 1)));
         @(posedge clk_i);
      end
      wr(OFS_CTRL, 8'h04);
      pulse_wait(10 * WD_LIM, n);
      check({15'h0, wd_exp}, 16'h0000);
      @(posedge clk_i);
      wr(OFS_THM_TH, 8'h5a);
      wr(OFS_LIMITS, 8'h00);
      srst_i <= 1'b1;
      @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(OFS_THM_TH, 8'h25);
      rd_chk(OFS_LIMITS, 8'hc4);
      rd_chk(OFS_CTRL, 8'h01);
      check({8'h00, cfg_b.limits}, 16'h00c0);
      close_out();
   end

endmodule : tb_top
